// ### rtl/mfr_consts.svh
// Constants of the multi-I/O flash read path
// Function
// - 6Bh: opcode, address, dummy byte, quad data out
// - Quad reads need quad enable status bit
// - Address increments per byte until deselect
// - BBh: address and mode two bits per clock
// - Mode bits 10 skip opcode next time
// - Other mode bits require opcode next time
// - Host may send continuous-mode reset first
// - EBh: quad address, mode, four dummy clocks
// - E7h: two dummy clocks, even address
// - Wrap inside aligned section of page
// - 77h: opcode, 24 dummy bits, wrap byte
// - Wrap disable bit; length 8 to 64
// - Wrap setting kept until rewritten
// - Device samples input on rising clock
// - Quad lanes carry every fourth bit
// - Device changes output on falling clock
`ifndef MFR_CONSTS_SVH
`define MFR_CONSTS_SVH

`define MFR_OP_QUAD_OUT  8'h6b
`define MFR_OP_DUAL_IO   8'hbb
`define MFR_OP_QUAD_IO   8'heb
`define MFR_OP_QUAD_WORD 8'he7
`define MFR_OP_WRAP_SET  8'h77

`define MFR_BITS_CMD     8'h08
`define MFR_BITS_ADDR    8'h18
`define MFR_BITS_MODE    8'h08
`define MFR_DUMMY_QOUT   8'h08
`define MFR_DUMMY_QIO    8'h04
`define MFR_DUMMY_QWORD  8'h02

`define MFR_CONT_MSB     5
`define MFR_CONT_LSB     4
`define MFR_CONT_VALUE   2'h2
`define MFR_WRAP_MSB     6
`define MFR_WRAP_LSB     4
`define MFR_WRAP_RESET   3'h1
`define MFR_WRAP_LEN_MIN 8'h08

`define MFR_W1           3'h1
`define MFR_W2           3'h2
`define MFR_W4           3'h4

`define MFR_SCLK_HALF    8'h0a
`define MFR_SYNC_RESET   6'h20

`endif

// ### rtl/mfr_pkg.sv
// Types of each end of the flash read link and lane helpers shared by both ends
`default_nettype none
package mfr_pkg;

  typedef enum logic [7:0] {
    MFR_D_IDLE  = 8'h01,
    MFR_D_CMD   = 8'h02,
    MFR_D_ADDR  = 8'h04,
    MFR_D_MODE  = 8'h08,
    MFR_D_DUMMY = 8'h10,
    MFR_D_WRAP  = 8'h20,
    MFR_D_DATA  = 8'h40,
    MFR_D_SKIP  = 8'h80
  } mfr_dstate_type;

  typedef enum logic [2:0] {
    MFR_H_IDLE = 3'h1,
    MFR_H_RUN  = 3'h2,
    MFR_H_END  = 3'h4
  } mfr_hstate_type;

  typedef enum logic [2:0] {
    MFR_OP_QUAD_OUT  = 3'h0,
    MFR_OP_DUAL_IO   = 3'h1,
    MFR_OP_QUAD_IO   = 3'h2,
    MFR_OP_QUAD_WORD = 3'h3,
    MFR_OP_WRAP_SET  = 3'h4,
    MFR_OP_CONT_RST  = 3'h5
  } mfr_op_type;

  // Shifts lane bits in, highest lane holding the most significant bit
  function automatic logic [31:0] lane_shift(input logic [31:0] sr, input logic [3:0] io, input logic [2:0] w);
    case (w)
      3'h2:    lane_shift = {sr[29:0], io[1:0]};
      3'h4:    lane_shift = {sr[27:0], io};
      default: lane_shift = {sr[30:0], io[0]};
    endcase
  endfunction : lane_shift

  // Top bits of a byte onto the lanes
  function automatic logic [3:0] lane_out(input logic [7:0] b, input logic [2:0] w);
    case (w)
      3'h2:    lane_out = {2'h0, b[7:6]};
      3'h4:    lane_out = b[7:4];
      default: lane_out = {3'h0, b[7]};
    endcase
  endfunction : lane_out

  function automatic logic [3:0] lane_oe(input logic [2:0] w);
    case (w)
      3'h2:    lane_oe = 4'h3;
      3'h4:    lane_oe = 4'hf;
      default: lane_oe = 4'h1;
    endcase
  endfunction : lane_oe

  // Clocks needed to move a number of bits over w lanes
  function automatic logic [7:0] div_clks(input logic [7:0] bits, input logic [2:0] w);
    case (w)
      3'h2:    div_clks = bits >> 1;
      3'h4:    div_clks = bits >> 2;
      default: div_clks = bits;
    endcase
  endfunction : div_clks

endpackage : mfr_pkg
`default_nettype wire

// ### rtl/mfr_link_if.sv
// Serial flash link between host controller and flash device
`timescale 1ns/1ps
`default_nettype none
interface mfr_link_if;
  logic       cs_n;
  logic       sclk;
  logic [3:0] host_io_o;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_o;
  logic [3:0] dev_io_oe;
  logic [3:0] io_line;

  // Wire level of each IO line; undriven lines float high
  assign io_line = (dev_io_oe & dev_io_o) | (~dev_io_oe & host_io_oe & host_io_o) | (~dev_io_oe & ~host_io_oe);

  modport host (output cs_n, output sclk, output host_io_o, output host_io_oe, input io_line);
  modport dev (input cs_n, input sclk, input io_line, output dev_io_o, output dev_io_oe);
endinterface : mfr_link_if
`default_nettype wire

// ### rtl/mfr_flash_dev.sv
// Flash device end: quad/dual read commands, continuous mode, wrapped burst
`timescale 1ns/1ps
`default_nettype none
`include "mfr_consts.svh"
module mfr_flash_dev (
  input  wire logic       clock,
  input  wire logic       rst,
  mfr_link_if.dev         link,
  input  wire logic       status_bit_nine,
  input  wire logic       mem_we,
  input  wire logic [7:0] mem_addr,
  input  wire logic [7:0] mem_wdata,
  output logic            cont_mode,
  output logic [2:0]      wrap_setting_bits
);

  logic [7:0]            mem [0:255];
  logic [5:0]            s1_q, s2_q, s3_q, f_q, f_d;
  logic                  prev_q;
  mfr_pkg::mfr_dstate_type st_q, st_d;
  logic [7:0]            cnt_q, cnt_d;
  logic [31:0]           sr_q, sr_d, sr_sh;
  logic [7:0]            cmd_q, cmd_d;
  logic [23:0]           addr_q, addr_d;
  logic                  cont_q, cont_d;
  logic [7:0]            ccmd_q, ccmd_d;
  logic [2:0]            wrap_q, wrap_d;
  logic [7:0]            sh_q, sh_d;
  logic [2:0]            rem_q, rem_d;
  logic [3:0]            out_q, out_d;
  logic [3:0]            oe_q, oe_d;
  logic [2:0]            w_q, w_d;
  logic                  cs_n_f;
  logic [3:0]            io_f;
  logic                  rise;
  logic                  fall;
  logic                  last;
  logic [7:0]            rd_byte;

  function automatic logic is_quad(input logic [7:0] op);
    is_quad = (op == `MFR_OP_QUAD_OUT) || (op == `MFR_OP_QUAD_IO) || (op == `MFR_OP_QUAD_WORD);
  endfunction : is_quad

  function automatic logic is_known(input logic [7:0] op);
    is_known = is_quad(op) || (op == `MFR_OP_DUAL_IO) || (op == `MFR_OP_WRAP_SET);
  endfunction : is_known

  // Lanes used for the address of each command
  function automatic logic [2:0] addr_w(input logic [7:0] op);
    case (op)
      `MFR_OP_DUAL_IO:   addr_w = `MFR_W2;
      `MFR_OP_QUAD_IO:   addr_w = `MFR_W4;
      `MFR_OP_QUAD_WORD: addr_w = `MFR_W4;
      default:           addr_w = `MFR_W1;
    endcase
  endfunction : addr_w

  // Address after one byte, folded inside the wrap section when enabled for EBh and E7h reads
  function automatic logic [23:0] next_addr(input logic [23:0] a, input logic [7:0] op, input logic [2:0] wr);
    logic [7:0] mask;
    logic [7:0] inc;
    mask = 8'((`MFR_WRAP_LEN_MIN << wr[2:1]) - 8'h01);
    inc  = a[7:0] + 8'h01;
    if (!wr[0] && (op == `MFR_OP_QUAD_IO || op == `MFR_OP_QUAD_WORD)) begin
      next_addr = {a[23:8], (a[7:0] & ~mask) | (inc & mask)};
    end else begin
      next_addr = a + 24'h000001;
    end
  endfunction : next_addr

  // Input filter: a bit changes once the second and third stages agree
  always_comb begin
    f_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & f_q);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s1_q   <= `MFR_SYNC_RESET;
      s2_q   <= `MFR_SYNC_RESET;
      s3_q   <= `MFR_SYNC_RESET;
      f_q    <= `MFR_SYNC_RESET;
      prev_q <= 1'b0;
    end else begin
      s1_q   <= {link.cs_n, link.sclk, link.io_line};
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      f_q    <= f_d;
      prev_q <= f_q[4];
    end
  end

  assign cs_n_f  = f_q[5];
  assign io_f    = f_q[3:0];
  assign rise    = f_q[4] & ~prev_q;
  assign fall    = ~f_q[4] & prev_q;
  assign last    = rise && (cnt_q == 8'h01);
  assign rd_byte = mem[addr_q[7:0]];

  always_ff @(posedge clock) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
  end

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    sr_d   = sr_q;
    cmd_d  = cmd_q;
    addr_d = addr_q;
    cont_d = cont_q;
    ccmd_d = ccmd_q;
    wrap_d = wrap_q;
    sh_d   = sh_q;
    rem_d  = rem_q;
    out_d  = out_q;
    oe_d   = oe_q;
    w_d    = w_q;
    sr_sh  = mfr_pkg::lane_shift(sr_q, io_f, w_q);
    if (rise) begin
      cnt_d = cnt_q - 8'h01;
      sr_d  = sr_sh;
    end
    if (cs_n_f) begin
      st_d = mfr_pkg::MFR_D_IDLE;
      oe_d = 4'h0;
      rem_d = 3'h0;
    end else begin
      case (st_q)
        mfr_pkg::MFR_D_IDLE: begin
          sr_d = 32'h0;
          // continuous mode starts at the address
          if (cont_q) begin
            cmd_d = ccmd_q;
            if (is_quad(ccmd_q) && !status_bit_nine) begin
              st_d = mfr_pkg::MFR_D_SKIP;
            end else begin
              st_d  = mfr_pkg::MFR_D_ADDR;
              w_d   = addr_w(ccmd_q);
              cnt_d = mfr_pkg::div_clks(`MFR_BITS_ADDR, addr_w(ccmd_q));
            end
          end else begin
            st_d  = mfr_pkg::MFR_D_CMD;
            w_d   = `MFR_W1;
            cnt_d = `MFR_BITS_CMD;
          end
        end
        mfr_pkg::MFR_D_CMD: begin
          if (last) begin
            cmd_d = sr_sh[7:0];
            if (!is_known(sr_sh[7:0]) || (is_quad(sr_sh[7:0]) && !status_bit_nine)) begin
              st_d = mfr_pkg::MFR_D_SKIP;
            end else begin
              st_d  = mfr_pkg::MFR_D_ADDR;
              w_d   = addr_w(sr_sh[7:0]);
              cnt_d = mfr_pkg::div_clks(`MFR_BITS_ADDR, addr_w(sr_sh[7:0]));
            end
          end
        end
        mfr_pkg::MFR_D_ADDR: begin
          if (last) begin
            addr_d = sr_sh[23:0];
            // quad output read takes a dummy byte
            if (cmd_q == `MFR_OP_QUAD_OUT) begin
              st_d  = mfr_pkg::MFR_D_DUMMY;
              cnt_d = `MFR_DUMMY_QOUT;
            end else if (cmd_q == `MFR_OP_WRAP_SET) begin
              st_d  = mfr_pkg::MFR_D_WRAP;
              cnt_d = `MFR_BITS_MODE;
            end else begin
              st_d  = mfr_pkg::MFR_D_MODE;
              cnt_d = mfr_pkg::div_clks(`MFR_BITS_MODE, w_q);
            end
          end
        end
        mfr_pkg::MFR_D_MODE: begin
          if (last) begin
            // mode bits 10 arm continuous mode
            cont_d = (sr_sh[`MFR_CONT_MSB:`MFR_CONT_LSB] == `MFR_CONT_VALUE);
            ccmd_d = cmd_q;
            // dual read: data follows the mode byte
            if (cmd_q == `MFR_OP_DUAL_IO) begin
              st_d  = mfr_pkg::MFR_D_DATA;
              rem_d = 3'h0;
            end else begin
              // four dummy clocks for EBh, two for the word read
              st_d  = mfr_pkg::MFR_D_DUMMY;
              cnt_d = (cmd_q == `MFR_OP_QUAD_IO) ? `MFR_DUMMY_QIO : `MFR_DUMMY_QWORD;
            end
          end
        end
        mfr_pkg::MFR_D_DUMMY: begin
          if (last) begin
            st_d  = mfr_pkg::MFR_D_DATA;
            w_d   = (cmd_q == `MFR_OP_DUAL_IO) ? `MFR_W2 : `MFR_W4;
            rem_d = 3'h0;
          end
        end
        mfr_pkg::MFR_D_WRAP: begin
          if (last) begin
            wrap_d = sr_sh[`MFR_WRAP_MSB:`MFR_WRAP_LSB];
            st_d   = mfr_pkg::MFR_D_SKIP;
          end
        end
        mfr_pkg::MFR_D_DATA: begin
          // output changes on the falling edge
          if (fall) begin
            oe_d = mfr_pkg::lane_oe(w_q);
            if (rem_q == 3'h0) begin
              out_d  = mfr_pkg::lane_out(rd_byte, w_q);
              sh_d   = 8'(rd_byte << w_q);
              rem_d  = 3'(mfr_pkg::div_clks(8'h08, w_q) - 8'h01);
              addr_d = next_addr(addr_q, cmd_q, wrap_q);
            end else begin
              out_d = mfr_pkg::lane_out(sh_q, w_q);
              sh_d  = 8'(sh_q << w_q);
              rem_d = rem_q - 3'h1;
            end
          end
        end
        mfr_pkg::MFR_D_SKIP: begin
          oe_d = 4'h0;
        end
        default: begin
          st_d = mfr_pkg::MFR_D_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q   <= mfr_pkg::MFR_D_IDLE;
      cnt_q  <= 8'h00;
      sr_q   <= 32'h0;
      cmd_q  <= 8'h00;
      addr_q <= 24'h0;
      cont_q <= 1'b0;
      ccmd_q <= 8'h00;
      wrap_q <= `MFR_WRAP_RESET;
      sh_q   <= 8'h00;
      rem_q  <= 3'h0;
      out_q  <= 4'h0;
      oe_q   <= 4'h0;
      w_q    <= `MFR_W1;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      sr_q   <= sr_d;
      cmd_q  <= cmd_d;
      addr_q <= addr_d;
      cont_q <= cont_d;
      ccmd_q <= ccmd_d;
      wrap_q <= wrap_d;
      sh_q   <= sh_d;
      rem_q  <= rem_d;
      out_q  <= out_d;
      oe_q   <= oe_d;
      w_q    <= w_d;
    end
  end

  assign link.dev_io_o  = out_q;
  assign link.dev_io_oe = oe_q;
  assign cont_mode         = cont_q;
  assign wrap_setting_bits = wrap_q;

endmodule : mfr_flash_dev
`default_nettype wire

// ### rtl/mfr_flash_host.sv
// Host controller end: issues read, wrap-setup and continuous-reset frames
`timescale 1ns/1ps
`default_nettype none
`include "mfr_consts.svh"
module mfr_flash_host (
  input  wire logic               clock,
  input  wire logic               rst,
  mfr_link_if.host                link,
  input  wire logic               req,
  input  wire mfr_pkg::mfr_op_type req_op,
  input  wire logic [23:0]        req_addr,
  input  wire logic [7:0]         req_mode,
  input  wire logic [7:0]         req_len,
  input  wire logic               req_cont,
  output logic                    busy,
  output logic                    rd_valid,
  output logic [7:0]              rd_data,
  output logic                    done
);

  logic [3:0]                 s1_q, s2_q, s3_q, f_q, f_d;
  mfr_pkg::mfr_hstate_type    st_q, st_d;
  logic [7:0]                 div_q, div_d;
  logic                       sclk_q, sclk_d, cs_n_q, cs_n_d;
  logic [2:0]                 ph_q, ph_d, np_q, np_d;
  logic [10:0]                cnt_q, cnt_d;
  logic [31:0]                sr_q, sr_d, in_q, in_d, ld [5];
  logic [3:0]                 out_q, out_d, oe_q, oe_d, bits_q, bits_d;
  logic [4:0][10:0]           pc_q, pc_d;
  logic [4:0][2:0]            pw_q, pw_d;
  logic [7:0]                 op_code_q, op_code_d, rd_data_q, rd_data_d;
  logic [23:0]                addr_q, addr_d;
  logic [7:0]                 mode_q, mode_d;
  logic                       rst_op_q, rst_op_d, rd_valid_q, rd_valid_d, done_q, done_d;
  logic                       tick, found;
  logic [2:0]                 w_cur, aw, nxt;

  function automatic logic [7:0] opcode_of(input mfr_pkg::mfr_op_type op);
    case (op)
      mfr_pkg::MFR_OP_QUAD_OUT:  opcode_of = `MFR_OP_QUAD_OUT;
      mfr_pkg::MFR_OP_DUAL_IO:   opcode_of = `MFR_OP_DUAL_IO;
      mfr_pkg::MFR_OP_QUAD_IO:   opcode_of = `MFR_OP_QUAD_IO;
      mfr_pkg::MFR_OP_QUAD_WORD: opcode_of = `MFR_OP_QUAD_WORD;
      default:                   opcode_of = `MFR_OP_WRAP_SET;
    endcase
  endfunction : opcode_of

  always_comb begin
    f_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & f_q);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s1_q <= 4'hf;
      s2_q <= 4'hf;
      s3_q <= 4'hf;
      f_q  <= 4'hf;
    end else begin
      s1_q <= link.io_line;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q  <= f_d;
    end
  end

  assign tick  = (div_q == `MFR_SCLK_HALF - 8'h01);
  assign w_cur = pw_q[ph_q];
  assign ld[0] = {op_code_q, 24'h0};
  assign ld[1] = {addr_q, 8'h00};
  assign ld[2] = rst_op_q ? 32'hffffffff : {mode_q, 24'h0};
  assign ld[3] = 32'h0;
  assign ld[4] = 32'h0;
  assign aw    = (req_op == mfr_pkg::MFR_OP_DUAL_IO) ? `MFR_W2 :
                 (req_op == mfr_pkg::MFR_OP_QUAD_IO || req_op == mfr_pkg::MFR_OP_QUAD_WORD) ? `MFR_W4 : `MFR_W1;

  always_comb begin
    st_d = st_q;
    div_d = tick ? 8'h00 : div_q + 8'h01;
    sclk_d = sclk_q;
    cs_n_d = cs_n_q;
    ph_d = ph_q;
    np_d = np_q;
    cnt_d = cnt_q;
    sr_d = sr_q;
    in_d = in_q;
    out_d = out_q;
    oe_d = oe_q;
    bits_d = bits_q;
    pc_d = pc_q;
    pw_d = pw_q;
    op_code_d = op_code_q;
    addr_d = addr_q;
    mode_d = mode_q;
    rst_op_d = rst_op_q;
    rd_data_d = rd_data_q;
    rd_valid_d = 1'b0;
    done_d = 1'b0;
    nxt = 3'h0;
    found = 1'b0;
    for (int i = 4; i >= 0; i--) begin
      if (3'(i) >= np_q && pc_q[i] != 11'h0) begin
        nxt = 3'(i);
        found = 1'b1;
      end
    end
    case (st_q)
      mfr_pkg::MFR_H_IDLE: begin
        if (req) begin
          st_d = mfr_pkg::MFR_H_RUN;
          cs_n_d = 1'b0;
          div_d = 8'h00;
          np_d = 3'h0;
          cnt_d = 11'h0;
          op_code_d = opcode_of(req_op);
          addr_d = req_addr;
          mode_d = req_mode;
          bits_d = 4'h0;
          rst_op_d = (req_op == mfr_pkg::MFR_OP_CONT_RST);
          // opcode left out in continuous mode
          pc_d[0] = (rst_op_d || (req_cont && aw != `MFR_W1)) ? 11'h0 : 11'(`MFR_BITS_CMD);
          pw_d[0] = `MFR_W1;
          pc_d[1] = rst_op_d ? 11'h0 : 11'(mfr_pkg::div_clks(`MFR_BITS_ADDR, aw));
          pw_d[1] = aw;
          // wrap byte after the 24 dummy bits
          // lines held high to clear the mode bits
          pc_d[2] = rst_op_d ? 11'(req_len) : (req_op == mfr_pkg::MFR_OP_QUAD_OUT) ? 11'h0 :
                    11'(mfr_pkg::div_clks(`MFR_BITS_MODE, aw));
          pw_d[2] = rst_op_d ? `MFR_W4 : aw;
          pc_d[3] = (req_op == mfr_pkg::MFR_OP_QUAD_OUT) ? 11'(`MFR_DUMMY_QOUT) :
                    (req_op == mfr_pkg::MFR_OP_QUAD_IO) ? 11'(`MFR_DUMMY_QIO) :
                    (req_op == mfr_pkg::MFR_OP_QUAD_WORD) ? 11'(`MFR_DUMMY_QWORD) : 11'h0;
          pw_d[3] = `MFR_W1;
          // dual data on two lines, quad on four
          pw_d[4] = (req_op == mfr_pkg::MFR_OP_DUAL_IO) ? `MFR_W2 : `MFR_W4;
          pc_d[4] = (req_op > mfr_pkg::MFR_OP_QUAD_WORD) ? 11'h0 :
                    11'({3'h0, req_len} << ((req_op == mfr_pkg::MFR_OP_DUAL_IO) ? 2 : 1));
        end
      end
      mfr_pkg::MFR_H_RUN: begin
        if (tick) begin
          if (!sclk_q && cnt_q != 11'h0) begin
            sclk_d = 1'b1;
            cnt_d  = cnt_q - 11'h001;
            if (ph_q == 3'h4) begin
              in_d   = mfr_pkg::lane_shift(in_q, f_q, w_cur);
              bits_d = bits_q + 4'(w_cur);
              if (bits_d == 4'h8) begin
                bits_d     = 4'h0;
                rd_data_d  = in_d[7:0];
                rd_valid_d = 1'b1;
              end
            end
          end else begin
            sclk_d = 1'b0;
            if (cnt_q == 11'h0) begin
              if (found) begin
                ph_d  = nxt;
                np_d  = nxt + 3'h1;
                cnt_d = pc_q[nxt];
                sr_d  = ld[nxt];
                out_d = mfr_pkg::lane_out(ld[nxt][31:24], pw_q[nxt]);
                oe_d  = (nxt < 3'h3) ? mfr_pkg::lane_oe(pw_q[nxt]) : 4'h0;
              end else begin
                st_d   = mfr_pkg::MFR_H_END;
                cs_n_d = 1'b1;
                oe_d   = 4'h0;
              end
            end else begin
              sr_d  = 32'(sr_q << w_cur);
              out_d = mfr_pkg::lane_out(sr_d[31:24], w_cur);
            end
          end
        end
      end
      mfr_pkg::MFR_H_END: begin
        if (tick) begin
          st_d   = mfr_pkg::MFR_H_IDLE;
          done_d = 1'b1;
        end
      end
      default: begin
        st_d = mfr_pkg::MFR_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= mfr_pkg::MFR_H_IDLE;
      div_q <= 8'h00;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      ph_q <= 3'h0;
      np_q <= 3'h0;
      cnt_q <= 11'h0;
      sr_q <= 32'h0;
      in_q <= 32'h0;
      out_q <= 4'h0;
      oe_q <= 4'h0;
      bits_q <= 4'h0;
      pc_q <= '0;
      pw_q <= '0;
      op_code_q <= 8'h00;
      addr_q <= 24'h0;
      mode_q <= 8'h00;
      rst_op_q <= 1'b0;
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      sclk_q <= sclk_d;
      cs_n_q <= cs_n_d;
      ph_q <= ph_d;
      np_q <= np_d;
      cnt_q <= cnt_d;
      sr_q <= sr_d;
      in_q <= in_d;
      out_q <= out_d;
      oe_q <= oe_d;
      bits_q <= bits_d;
      pc_q <= pc_d;
      pw_q <= pw_d;
      op_code_q <= op_code_d;
      addr_q <= addr_d;
      mode_q <= mode_d;
      rst_op_q <= rst_op_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      done_q <= done_d;
    end
  end

  assign link.cs_n       = cs_n_q;
  assign link.sclk       = sclk_q;
  assign link.host_io_o  = out_q;
  assign link.host_io_oe = oe_q;
  assign busy     = (st_q != mfr_pkg::MFR_H_IDLE);
  assign rd_valid = rd_valid_q;
  assign rd_data  = rd_data_q;
  assign done     = done_q;

endmodule : mfr_flash_host
`default_nettype wire

// ### testbench/mfr_link_props.sv
// Link protocol checks for the flash read path
`timescale 1ns/1ps
`default_nettype none
module mfr_link_props (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic [3:0] host_io_o,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io_o,
  input wire logic [3:0] dev_io_oe
);
  logic [4:0] hi_q;
  logic [4:0] hi_d;
  // Cycles chip select has been high, saturating
  always_comb hi_d = (rst || !cs_n) ? 5'h0 : (hi_q == 5'h1f) ? hi_q : hi_q + 5'h1;
  always_ff @(posedge clock) hi_q <= hi_d;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_rise; !sclk ##1 sclk; endsequence
  sequence s_high_hold; sclk [*8]; endsequence
  property p_half; s_rise |=> s_high_hold; endproperty
  property p_hold; sclk && $past(sclk) |-> $stable(host_io_o) && $stable(host_io_oe); endproperty
  property p_idle; cs_n && $past(cs_n) |-> !sclk; endproperty
  property p_clash; (dev_io_oe & host_io_oe) == 4'h0; endproperty
  property p_off; hi_q >= 5'h0c |-> dev_io_oe == 4'h0; endproperty
  property p_gap; $rose(cs_n) |=> cs_n [*8]; endproperty
  property p_start; dev_io_oe != 4'h0 && $past(dev_io_oe) == 4'h0 |-> !cs_n && !sclk; endproperty
  property p_chg; dev_io_oe != 4'h0 && $changed(dev_io_o) |-> !sclk; endproperty
  property p_width; dev_io_oe == 4'h0 || dev_io_oe == 4'h3 || dev_io_oe == 4'hf; endproperty
  a_half: assert property (p_half) else $error("sclk high phase short");
  a_hold: assert property (p_hold) else $error("host lanes moved in high phase");
  a_idle: assert property (p_idle) else $error("sclk not idle low");
  a_clash: assert property (p_clash) else $error("both ends drive a lane");
  a_off: assert property (p_off) else $error("device drives while deselected");
  a_gap: assert property (p_gap) else $error("deselect gap short");
  a_start: assert property (p_start) else $error("device drive starts badly");
  a_chg: assert property (p_chg) else $error("device data moved in high phase");
  a_width: assert property (p_width) else $error("device lane enable odd");
endmodule : mfr_link_props
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for both ends of the flash read link
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                clock, rst, status_bit_nine, mem_we, cont_mode;
  logic                req, req_cont, busy, rd_valid, done;
  logic [7:0]          mem_addr, mem_wdata, req_mode, req_len, rd_data;
  logic [2:0]          wrap_setting_bits;
  logic [23:0]         req_addr;
  mfr_pkg::mfr_op_type req_op;
  int                  n_mismatch;
  int                  check_count;
  logic [7:0]          got[$];

  mfr_link_if link_inst ();
  mfr_flash_dev mfr_flash_dev_inst (.clock(clock), .rst(rst), .link(link_inst),
    .status_bit_nine(status_bit_nine), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .cont_mode(cont_mode), .wrap_setting_bits(wrap_setting_bits));
  mfr_flash_host mfr_flash_host_inst (.clock(clock), .rst(rst), .link(link_inst), .req(req),
    .req_op(req_op), .req_addr(req_addr), .req_mode(req_mode), .req_len(req_len), .req_cont(req_cont),
    .busy(busy), .rd_valid(rd_valid), .rd_data(rd_data), .done(done));
  mfr_link_props mfr_link_props_inst (.clock(clock), .rst(rst), .cs_n(link_inst.cs_n),
    .sclk(link_inst.sclk), .host_io_o(link_inst.host_io_o), .host_io_oe(link_inst.host_io_oe),
    .dev_io_o(link_inst.dev_io_o), .dev_io_oe(link_inst.dev_io_oe));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("compares %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  // One request; bytes compared against memory image, wsz 0 means no wrap
  task automatic rd(input logic [2:0] op, input logic [23:0] a, input logic [7:0] m, input logic [7:0] n,
                    input logic c, input logic [7:0] wsz, input logic fl);
    logic [7:0] e;
    @(negedge clock);
    req = 1'b1;
    req_op = mfr_pkg::mfr_op_type'(op);
    req_addr = a;
    req_mode = m;
    req_len = n;
    req_cont = c;
    @(negedge clock);
    req = 1'b0;
    check({7'h0, busy}, 8'h01);
    got.delete();
    for (int i = 0; i < 8000 && done !== 1'b1; i++) begin
      @(posedge clock);
      #1;
      if (rd_valid === 1'b1) got.push_back(rd_data);
    end
    check({7'h0, done}, 8'h01);
    check(8'(got.size()), (op > 3'h3) ? 8'h0 : n);
    foreach (got[i]) begin
      e = (wsz == 8'h0) ? a[7:0] + 8'(i) : (a[7:0] & ~(wsz - 8'h1)) | ((a[7:0] + 8'(i)) & (wsz - 8'h1));
      check(got[i], fl ? 8'hff : e ^ 8'ha5);
    end
  endtask : rd

  task automatic t_basic();
    check({5'h0, wrap_setting_bits}, 8'h01);
    rd(3'h0, 24'h0000fe, 8'h00, 8'h03, 1'b0, 8'h0, 1'b0);
    rd(3'h1, 24'h000010, 8'h20, 8'h02, 1'b0, 8'h0, 1'b0);
    check({7'h0, cont_mode}, 8'h01);
    rd(3'h1, 24'h000040, 8'h00, 8'h02, 1'b1, 8'h0, 1'b0);
    check({7'h0, cont_mode}, 8'h00);
    rd(3'h1, 24'h000041, 8'hff, 8'h01, 1'b0, 8'h0, 1'b0);
    $display("test basic done");
  endtask : t_basic

  task automatic t_refuse();
    @(negedge clock);
    status_bit_nine = 1'b0;
    rd(3'h2, 24'h000020, 8'h20, 8'h02, 1'b0, 8'h0, 1'b1);
    check({7'h0, cont_mode}, 8'h00);
    rd(3'h0, 24'h000020, 8'h00, 8'h01, 1'b0, 8'h0, 1'b1);
    @(negedge clock);
    status_bit_nine = 1'b1;
    $display("test refuse done");
  endtask : t_refuse

  task automatic t_wrap();
    for (int k = 0; k < 4; k++) begin
      rd(3'h4, 24'h0, {1'b0, 2'(k), 5'h0}, 8'h00, 1'b0, 8'h0, 1'b0);
      check({5'h0, wrap_setting_bits}, {5'h0, 2'(k), 1'b0});
      rd(k[0] ? 3'h3 : 3'h2, 24'h00007e + 24'(8 << k), 8'h00, 8'h03, 1'b0, 8'(8 << k), 1'b0);
    end
    rd(3'h2, 24'h0001be, 8'h00, 8'h03, 1'b0, 8'h40, 1'b0);
    rd(3'h4, 24'h0, 8'h10, 8'h00, 1'b0, 8'h0, 1'b0);
    check({5'h0, wrap_setting_bits}, 8'h01);
    rd(3'h3, 24'h0000be, 8'h00, 8'h03, 1'b0, 8'h0, 1'b0);
    $display("test wrap done");
  endtask : t_wrap

  task automatic t_cont();
    rd(3'h2, 24'h000030, 8'h20, 8'h01, 1'b0, 8'h0, 1'b0);
    rd(3'h2, 24'h000031, 8'h20, 8'h02, 1'b1, 8'h0, 1'b0);
    check({7'h0, cont_mode}, 8'h01);
    // Continuous re-entry must still honour quad enable
    @(negedge clock);
    status_bit_nine = 1'b0;
    rd(3'h2, 24'h000033, 8'h20, 8'h01, 1'b1, 8'h0, 1'b1);
    check({7'h0, cont_mode}, 8'h01);
    @(negedge clock);
    status_bit_nine = 1'b1;
    rd(3'h5, 24'h0, 8'h00, 8'h08, 1'b0, 8'h0, 1'b0);
    check({7'h0, cont_mode}, 8'h00);
    rd(3'h3, 24'h000032, 8'h00, 8'h02, 1'b0, 8'h0, 1'b0);
    $display("test cont done");
  endtask : t_cont

  initial begin
    rst = 1'b1;
    status_bit_nine = 1'b1;
    mem_we = 1'b0;
    mem_addr = 8'h0;
    mem_wdata = 8'h0;
    req = 1'b0;
    req_op = mfr_pkg::MFR_OP_QUAD_OUT;
    req_addr = 24'h0;
    req_mode = 8'h0;
    req_len = 8'h0;
    req_cont = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    repeat (10) @(negedge clock);
    rst = 1'b0;
    for (int i = 0; i < 256; i++) begin
      @(negedge clock);
      mem_we = 1'b1;
      mem_addr = 8'(i);
      mem_wdata = 8'(i) ^ 8'ha5;
    end
    @(negedge clock);
    mem_we = 1'b0;
    repeat (8) @(negedge clock);
    t_basic();
    t_refuse();
    t_wrap();
    t_cont();
    close_out();
  end

  // Cuts a hang short
  initial begin
    #300000;
    n_mismatch++;
    close_out();
  end
endmodule : tb
`default_nettype wire
